/* rtl/pin_sync.sv */
/*
  three-flop synchroniser for a group of pins; a change is taken once
  the second and third flops agree. assumes pins asynchronous to clk.
*/
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 6,
  parameter logic [WIDTH-1:0] IDLE = '1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } sync_t;

  sync_t s;
  sync_t next_s;

  always_comb begin
    next_s = s;
    next_s.s1 = pin;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        next_s.lvl[i] = s.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s <= '{s1: IDLE, s2: IDLE, s3: IDLE, lvl: IDLE};
    end else begin
      s <= next_s;
    end
  end

  assign level = s.lvl;
endmodule // pin_sync

/* rtl/uart_line_modem_status.sv */
/*
  uart line status, modem status, modem control upper bits, rs-485
  turnaround, scratch pad and flow hysteresis behind an axi4-lite slave.
  assumes receiver, transmitter, fifos and enhanced feature bits live
  outside and report through the rx, tx and enable ports.
*/
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
// Contract
// [RQ1] loopback bit selects internal local loopback
// [RQ2] xon-any: any received character resumes transmit
// [RQ3] infrared bit loaded from strap after reset
// [RQ4] infrared routes through encoder, idle tx low
// [RQ5] prescaler bit divides baud clock by four
// [RQ6] line status interrupt on any error
// [RQ7] data ready while receive fifo holds data
// [RQ8] overrun when full, character dropped, fifo kept
// [RQ9] parity and framing flags follow head character
// [RQ10] break flag, one break character per break
// [RQ11] holding empty sets on move, clears on write
// [RQ12] transmitter empty only when fully idle
// [RQ13] fifo error while any stored character errs
// [RQ14] delta cts dsr cd set on change
// [RQ15] delta ring on ring end only
// [RQ16] status bits complement pins, mirror in loopback
// [RQ17] auto cts pauses after current character
// [RQ18] turnaround delay 0 to 15 bit times
// [RQ19] turnaround writes only with enhanced enable
// [RQ20] scratch pad resets to all ones
// [RQ21] hysteresis valid only with trigger table d
// [RQ22] hysteresis resets to zero, next level
// [RQ23] rs-485 rts high while sending, tx interrupt moves
// [RQ24] enhanced control bits locked without enable
// [RQ25] status reads clear deltas and overrun
// [RQ26] sixteen entry hysteresis lookup table
`timescale 1ns/100ps
module uart_line_modem_status
  import uart_lms_pkg::*;
#(
  parameter int RX_DEPTH = 64
) (
  input wire logic clk,
  input wire logic resetn,
  input wire axil_req_t axi_req,
  output axil_rsp_t axi_rsp,
  input wire rx_char_t rx_char,
  input wire logic rx_pop,
  input wire tx_event_t tx_ev,
  input wire logic enh_enable,
  input wire logic auto_cts_enable,
  input wire logic lsr_int_enable,
  input wire logic msr_int_enable,
  input wire modem_pins_t modem_in,
  input wire logic rx_pin,
  input wire logic ir_strap_pin,
  input wire logic tx_serial,
  input wire logic ir_tx_enc,
  input wire logic ir_rx_dec,
  output logic tx_pin,
  output logic rx_to_receiver,
  output logic rts_n,
  output logic dtr_n,
  output logic loopback,
  output logic xon_any_resume,
  output logic tx_hold,
  output logic baud_clk_en,
  output logic lsr_irq,
  output logic msr_irq,
  output logic tx_irq_src,
  output logic [5:0] hyst_amount,
  output logic hyst_active,
  output logic data_ready
);
  localparam int PW = $clog2(RX_DEPTH);
  localparam int CW = $clog2(RX_DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(RX_DEPTH);

  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_off;
    logic w_got;
    logic [7:0] wbyte;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] mc;
    logic [7:0] scratch_pad;
    logic [7:0] fc;
    logic [3:0] turn;
    logic [3:0] delta;
    logic [3:0] prev;
    logic overrun;
    logic [RX_DEPTH-1:0][2:0] err;
    logic [PW-1:0] rd;
    logic [PW-1:0] wr;
    logic [CW-1:0] cnt;
    logic [CW-1:0] err_cnt;
    logic brk_hold;
    logic thr_empty;
    logic tsr_busy;
    rs485_state_t rs;
    logic [3:0] turn_cnt;
    logic [1:0] pre_cnt;
    logic baud_en;
    logic [1:0] strap_cnt;
    logic rts_n;
    logic dtr_n;
    logic tx_pin;
    logic rx_recv;
    logic xon_pulse;
  } state_t;

  state_t s;
  state_t next_s;
  logic [5:0] pins;
  logic [3:0] msr_now;
  logic [7:0] lsr_now;
  logic [2:0] head;
  logic tx_empty;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  pin_sync #(
    .WIDTH(6),
    .IDLE(PIN_IDLE)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .pin({ir_strap_pin, rx_pin, modem_in.cd_n, modem_in.ri_n, modem_in.dsr_n,
          modem_in.cts_n}),
    .level(pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status words
  always_comb begin
    if (s.mc[MC_LOOP]) begin
      msr_now = {s.mc[MC_OUT2], s.mc[MC_FLOW_SEL], s.mc[MC_DTR], s.mc[MC_RTS]}; // see [RQ16]
    end else begin
      msr_now = ~pins[3:0]; // see [RQ16]
    end
    head = s.err[s.rd];
    tx_empty = s.thr_empty && !s.tsr_busy; // see [RQ12]
    lsr_now = 8'h00;
    lsr_now[LS_DATA_READY] = (s.cnt != '0); // see [RQ7]
    lsr_now[LS_OVERRUN] = s.overrun;
    lsr_now[LS_PARITY] = (s.cnt != '0) && head[0]; // see [RQ9]
    lsr_now[LS_FRAMING] = (s.cnt != '0) && head[1]; // see [RQ9]
    lsr_now[LS_BREAK] = ((s.cnt != '0) && head[2]) || s.brk_hold; // see [RQ10]
    lsr_now[LS_THR_EMPTY] = s.thr_empty;
    lsr_now[LS_TX_EMPTY] = tx_empty;
    lsr_now[LS_FIFO_ERR] = (s.err_cnt != '0); // see [RQ13]
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic do_write;
    logic do_read;
    logic push;
    logic pop;
    logic push_err;
    logic pop_err;
    logic [3:0] now_delta;
    logic [7:0] wmask;
    do_write = 1'b0;
    do_read = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    push_err = 1'b0;
    pop_err = 1'b0;
    now_delta = 4'h0;
    wmask = 8'h00;
    next_s = s;
    next_s.xon_pulse = 1'b0;

    // bus write channel
    if (axi_req.awvalid && !s.aw_got && !s.bvalid) begin
      next_s.aw_got = 1'b1;
      next_s.aw_off = axi_req.awaddr;
    end
    if (axi_req.wvalid && !s.w_got && !s.bvalid) begin
      next_s.w_got = 1'b1;
      next_s.wbyte = axi_req.wdata[7:0];
      next_s.wlane = axi_req.wstrb[0];
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      do_write = 1'b1;
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
    end
    if (s.bvalid && axi_req.bready) begin
      next_s.bvalid = 1'b0;
    end
    if (do_write) begin
      case (s.aw_off)
        OFF_MODEM_CONTROL: begin
          wmask = enh_enable ? 8'hff : 8'h1f; // see [RQ24]
          if (s.wlane) begin
            next_s.mc = (s.mc & ~wmask) | (s.wbyte & wmask); // see [RQ1] [RQ2] [RQ5]
          end
        end
        OFF_MODEM_STATUS: begin
          if (s.wlane && enh_enable) begin
            next_s.turn = s.wbyte[7:4]; // see [RQ19]
          end
        end
        OFF_SCRATCH_PAD: begin
          if (s.wlane) begin
            next_s.scratch_pad = s.wbyte;
          end
        end
        OFF_FEATURE_CONTROL: begin
          if (s.wlane) begin
            next_s.fc = s.wbyte;
          end
        end
        OFF_LINE_STATUS: begin
          next_s.bresp = RESP_OKAY;
        end
        default: begin
          next_s.bresp = RESP_SLVERR;
        end
      endcase
    end

    // bus read channel
    if (s.rvalid && axi_req.rready) begin
      next_s.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !s.rvalid) begin
      do_read = 1'b1;
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = 32'h0;
      case (axi_req.araddr)
        OFF_MODEM_CONTROL: next_s.rdata[7:0] = s.mc;
        OFF_LINE_STATUS: begin
          next_s.rdata[7:0] = lsr_now;
          next_s.overrun = 1'b0; // see [RQ25]
        end
        OFF_MODEM_STATUS: begin
          next_s.rdata[7:0] = {msr_now, s.delta};
          next_s.delta = 4'h0; // see [RQ25]
        end
        OFF_SCRATCH_PAD: next_s.rdata[7:0] = s.scratch_pad;
        OFF_FEATURE_CONTROL: next_s.rdata[7:0] = s.fc;
        default: next_s.rresp = RESP_SLVERR;
      endcase
    end

    // modem deltas, set wins over the read clear
    next_s.prev = msr_now;
    now_delta[0] = s.prev[0] ^ msr_now[0]; // see [RQ14]
    now_delta[1] = s.prev[1] ^ msr_now[1]; // see [RQ14]
    now_delta[2] = s.prev[2] && !msr_now[2]; // see [RQ15]
    now_delta[3] = s.prev[3] ^ msr_now[3]; // see [RQ14]
    next_s.delta = next_s.delta | now_delta;

    // receive error shadow of the fifo
    if (rx_char.valid) begin
      next_s.xon_pulse = s.mc[MC_XON_ANY]; // see [RQ2]
      if (s.cnt == FULL) begin
        next_s.overrun = 1'b1; // see [RQ8]
      end else if (!(rx_char.brk && s.brk_hold)) begin
        push = 1'b1; // see [RQ10]
      end
    end
    if (rx_char.brk && rx_char.valid) begin
      next_s.brk_hold = 1'b1; // see [RQ10]
    end else if (pins[4]) begin
      next_s.brk_hold = 1'b0; // see [RQ10]
    end
    pop = rx_pop && (s.cnt != '0);
    push_err = rx_char.par_err || rx_char.frm_err || rx_char.brk;
    pop_err = |head;
    if (push) begin
      next_s.err[s.wr] = {rx_char.brk, rx_char.frm_err, rx_char.par_err};
      next_s.wr = PW'(s.wr + 1'b1);
    end
    if (pop) begin
      next_s.rd = PW'(s.rd + 1'b1);
    end
    next_s.cnt = CW'(s.cnt + CW'(push) - CW'(pop)); // see [RQ7]
    next_s.err_cnt = CW'(s.err_cnt + CW'(push && push_err) - CW'(pop && pop_err)); // see [RQ13]

    // transmit flags, set wins over the host write clear
    if (tx_ev.write) begin
      next_s.thr_empty = 1'b0; // see [RQ11]
    end
    if (tx_ev.load && (!tx_ev.fifo_mode || tx_ev.fifo_empty)) begin
      next_s.thr_empty = 1'b1; // see [RQ11]
    end
    if (tx_ev.shift_done) begin
      next_s.tsr_busy = 1'b0;
    end
    if (tx_ev.load) begin
      next_s.tsr_busy = 1'b1; // see [RQ12]
    end

    // rs-485 direction
    case (s.rs)
      RS_IDLE: begin
        if (tx_ev.write) begin
          next_s.rs = RS_SEND; // see [RQ23]
        end
      end
      RS_SEND: begin
        if (tx_ev.shift_done && next_s.thr_empty && !tx_ev.load) begin
          next_s.rs = (s.turn == 4'h0) ? RS_IDLE : RS_TURN; // see [RQ18]
          next_s.turn_cnt = s.turn;
        end
      end
      RS_TURN: begin
        if (tx_ev.write) begin
          next_s.rs = RS_SEND;
        end else if (tx_ev.bit_tick) begin
          next_s.turn_cnt = s.turn_cnt - 4'h1; // see [RQ18]
          if (s.turn_cnt == 4'h1) begin
            next_s.rs = RS_IDLE;
          end
        end
      end
      default: next_s.rs = RS_IDLE;
    endcase
    if (s.fc[FC_RS485]) begin
      next_s.rts_n = (next_s.rs != RS_IDLE); // see [RQ23]
    end else begin
      next_s.rts_n = s.mc[MC_LOOP] || !s.mc[MC_RTS];
    end
    next_s.dtr_n = s.mc[MC_LOOP] || !s.mc[MC_DTR];

    // prescaler
    next_s.pre_cnt = s.mc[MC_PRESCALE] ? 2'(s.pre_cnt + 1'b1) : 2'h0;
    next_s.baud_en = !s.mc[MC_PRESCALE] || (s.pre_cnt == PRESCALE_LAST); // see [RQ5]

    // infrared strap capture after release
    if (s.strap_cnt != 2'h0) begin
      next_s.strap_cnt = s.strap_cnt - 2'h1;
      if (s.strap_cnt == 2'h1) begin
        next_s.mc[MC_IR] = pins[5]; // see [RQ3]
      end
    end

    // serial path
    if (s.mc[MC_IR]) begin
      next_s.tx_pin = (s.mc[MC_LOOP] || tx_empty) ? 1'b0 : ir_tx_enc; // see [RQ4]
      next_s.rx_recv = s.mc[MC_LOOP] ? tx_serial : ir_rx_dec; // see [RQ4]
    end else begin
      next_s.tx_pin = s.mc[MC_LOOP] ? 1'b1 : tx_serial;
      next_s.rx_recv = s.mc[MC_LOOP] ? tx_serial : pins[4]; // see [RQ1]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s <= '0;
      s.mc <= MODEM_CONTROL_RESET; // see [RQ24]
      s.scratch_pad <= SCRATCH_RESET; // see [RQ20]
      s.fc <= FEATURE_RESET; // see [RQ22]
      s.turn <= TURN_RESET;
      s.thr_empty <= 1'b1;
      s.rs <= RS_IDLE;
      s.strap_cnt <= STRAP_WAIT;
      s.rts_n <= 1'b1;
      s.dtr_n <= 1'b1;
      s.tx_pin <= 1'b1;
      s.rx_recv <= 1'b1;
      s.baud_en <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign axi_rsp.awready = !s.aw_got && !s.bvalid;
  assign axi_rsp.wready = !s.w_got && !s.bvalid;
  assign axi_rsp.bvalid = s.bvalid;
  assign axi_rsp.bresp = s.bresp;
  assign axi_rsp.arready = !s.rvalid;
  assign axi_rsp.rvalid = s.rvalid;
  assign axi_rsp.rdata = s.rdata;
  assign axi_rsp.rresp = s.rresp;

  assign tx_pin = s.tx_pin;
  assign rx_to_receiver = s.rx_recv;
  assign rts_n = s.rts_n;
  assign dtr_n = s.dtr_n;
  assign loopback = s.mc[MC_LOOP]; // see [RQ1]
  assign xon_any_resume = s.xon_pulse;
  assign tx_hold = auto_cts_enable && (s.mc[MC_FLOW_SEL] ? pins[1] : pins[0]); // see [RQ17]
  assign baud_clk_en = s.baud_en;
  assign lsr_irq = lsr_int_enable && (s.overrun || (s.err_cnt != '0)); // see [RQ6]
  assign msr_irq = msr_int_enable && (s.delta != 4'h0); // see [RQ14] [RQ15]
  assign tx_irq_src = s.fc[FC_RS485] ? tx_empty : s.thr_empty; // see [RQ23]
  assign hyst_active = (s.fc[7:6] == TABLE_D); // see [RQ21]
  assign hyst_amount = hyst_active ? HYST_TABLE[s.fc[3:0]] : 6'h00; // see [RQ26]
  assign data_ready = (s.cnt != '0);
endmodule // uart_line_modem_status

/* rtl/uart_lms_pkg.sv */
/*
  package: register offsets, field positions, reset values, timing counts,
  bus carriers and state codes for the uart line and modem status block.
  assumes a 32-bit axi4-lite register bus, one aligned word per register.
*/
package uart_lms_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFF_MODEM_CONTROL = 8'h00;
  localparam logic [7:0] OFF_LINE_STATUS = 8'h04;
  localparam logic [7:0] OFF_MODEM_STATUS = 8'h08;
  localparam logic [7:0] OFF_SCRATCH_PAD = 8'h0c;
  localparam logic [7:0] OFF_FEATURE_CONTROL = 8'h10;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // modem_control fields
  localparam int MC_DTR = 0;
  localparam int MC_RTS = 1;
  localparam int MC_FLOW_SEL = 2;
  localparam int MC_OUT2 = 3;
  localparam int MC_LOOP = 4;
  localparam int MC_XON_ANY = 5;
  localparam int MC_IR = 6;
  localparam int MC_PRESCALE = 7;
  localparam int MC_ENH_LO = 5;

  // line_status fields
  localparam int LS_DATA_READY = 0;
  localparam int LS_OVERRUN = 1;
  localparam int LS_PARITY = 2;
  localparam int LS_FRAMING = 3;
  localparam int LS_BREAK = 4;
  localparam int LS_THR_EMPTY = 5;
  localparam int LS_TX_EMPTY = 6;
  localparam int LS_FIFO_ERR = 7;

  // feature_control fields
  localparam int FC_RS485 = 5;
  localparam logic [1:0] TABLE_D = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and counts
  localparam logic [7:0] MODEM_CONTROL_RESET = 8'h00;
  localparam logic [7:0] SCRATCH_RESET = 8'hff;
  localparam logic [7:0] FEATURE_RESET = 8'h00;
  localparam logic [3:0] TURN_RESET = 4'h0;
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic [5:0] PIN_IDLE = 6'h3f;

  // hysteresis amount in characters, entry zero is next trigger level
  localparam logic [15:0][5:0] HYST_TABLE = {
    6'h34, 6'h30, 6'h2c, 6'h28, 6'h24, 6'h1c, 6'h14, 6'h0c,
    6'h20, 6'h18, 6'h10, 6'h08, 6'h08, 6'h06, 6'h04, 6'h00};

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic valid;
    logic par_err;
    logic frm_err;
    logic brk;
  } rx_char_t;

  typedef struct packed {
    logic write;
    logic load;
    logic shift_done;
    logic fifo_empty;
    logic fifo_mode;
    logic bit_tick;
  } tx_event_t;

  typedef struct packed {
    logic cd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } modem_pins_t;

  typedef enum logic [2:0] {
    RS_IDLE = 3'b001,
    RS_SEND = 3'b010,
    RS_TURN = 3'b100
  } rs485_state_t;

endpackage

/* test/modem_partner.sv */
/*
  far side model: modem handshake pins and a serial line plugged back.
  assumes the bench sets the pin levels through set_pins.
*/
`timescale 1ns/100ps
module modem_partner
  import uart_lms_pkg::*;
(
  input wire logic clk,
  input wire logic tx_pin,
  output modem_pins_t modem_in,
  output logic rx_pin
);
  initial begin
    modem_in = '1;
    rx_pin = 1'b1;
  end
  // line echoes what the device sends
  always @(posedge clk) begin
    rx_pin <= tx_pin;
  end
  // cts_n high asks the device to pause, low resumes, unless MC_FLOW_SEL is set and dsr_n is used instead
  task automatic set_pins(input modem_pins_t p);
    @(posedge clk);
    modem_in <= p;
  endtask
endmodule // modem_partner

/* test/tb_uart_line_modem_status.sv */
/*
  bench: register, line status, modem status, rs-485 and hysteresis runs.
  assumes the package offsets and an rx depth of four.
*/
`timescale 1ns/100ps
module tb_uart_line_modem_status
  import uart_lms_pkg::*;
;
  logic clk, resetn, rx_pop, rx_pin, ir_strap_pin, tx_serial, ir_tx_enc, ir_rx_dec;
  logic enh_enable, auto_cts_enable, lsr_int_enable, msr_int_enable;
  logic tx_pin, rx_to_receiver, rts_n, dtr_n, loopback, xon_any_resume, tx_hold;
  logic baud_clk_en, lsr_irq, msr_irq, tx_irq_src, hyst_active, data_ready;
  logic [5:0] hyst_amount;
  axil_req_t axi_req;
  axil_rsp_t axi_rsp;
  rx_char_t rx_char;
  tx_event_t tx_ev;
  modem_pins_t modem_in;
  logic [33:0] q_d[$];
  logic [33:0] q_m[$];
  logic [31:0] v;
  int fails, checks_done, cyc, n;
  int seed = 15;
  uart_line_modem_status #(.RX_DEPTH(4)) uart_line_modem_status_inst (.clk, .resetn, .axi_req,
    .axi_rsp, .rx_char, .rx_pop, .tx_ev, .enh_enable, .auto_cts_enable, .lsr_int_enable,
    .msr_int_enable, .modem_in, .rx_pin, .ir_strap_pin, .tx_serial, .ir_tx_enc, .ir_rx_dec,
    .tx_pin, .rx_to_receiver, .rts_n, .dtr_n, .loopback, .xon_any_resume, .tx_hold,
    .baud_clk_en, .lsr_irq, .msr_irq, .tx_irq_src, .hyst_amount, .hyst_active, .data_ready);
  modem_partner modem_partner_inst (.clk, .tx_pin, .modem_in, .rx_pin);
  ////////////////////////////////////////
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w, b;
    @(posedge clk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= {24'h0, d};
    axi_req.wstrb <= 4'hf;
    axi_req.bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b0;
    while (!b) begin
      @(posedge clk);
      if (aw && axi_rsp.awready) begin
        aw = 1'b0;
        axi_req.awvalid <= 1'b0;
      end
      if (w && axi_rsp.wready) begin
        w = 1'b0;
        axi_req.wvalid <= 1'b0;
      end
      if (axi_rsp.bvalid) begin
        b = 1'b1;
        axi_req.bready <= 1'b0;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] d, input logic [33:0] m = '1);
    logic ar, r;
    q_d.push_back(d);
    q_m.push_back(m);
    @(posedge clk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    ar = 1'b1;
    r = 1'b0;
    while (!r) begin
      @(posedge clk);
      if (ar && axi_rsp.arready) begin
        ar = 1'b0;
        axi_req.arvalid <= 1'b0;
      end
      if (axi_rsp.rvalid) begin
        r = 1'b1;
        axi_req.rready <= 1'b0;
      end
    end
  endtask
  task automatic push(input logic p);
    @(posedge clk);
    rx_char <= '{1'b1, p, 1'b0, 1'b0};
    @(posedge clk);
    rx_char <= '0;
  endtask
  task automatic pop;
    @(posedge clk);
    rx_pop <= 1'b1;
    @(posedge clk);
    rx_pop <= 1'b0;
  endtask
  task automatic tev(input logic [5:0] e);
    @(posedge clk);
    tx_ev <= tx_event_t'(e | 6'h04);
    @(posedge clk);
    tx_ev <= tx_event_t'(6'h04);
  endtask
  task automatic settle;
    repeat (10) @(posedge clk);
  endtask
  task automatic rsx;
    tev(6'h20);
    @(posedge clk);
    check(rts_n, 1);
    tev(6'h10);
    tev(6'h08);
    repeat (2) tev(6'h01);
    check(rts_n, 1);
    tev(6'h01);
    settle();
    check(rts_n, 0);
    check(tx_irq_src, 1);
  endtask
  ////////////////////////////////////////
  always @(posedge clk) begin
    {tx_serial, ir_tx_enc, ir_rx_dec} <= 3'($random(seed));
    if (axi_rsp.rvalid && axi_req.rready) begin
      check({axi_rsp.rresp, axi_rsp.rdata} & q_m[0], q_d[0] & q_m[0]);
      void'(q_d.pop_front());
      void'(q_m.pop_front());
    end
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {resetn, rx_pop, enh_enable, auto_cts_enable, lsr_int_enable, msr_int_enable} = '0;
    {tx_serial, ir_tx_enc, ir_rx_dec} = '0;
    ir_strap_pin = 1'b1;
    axi_req = '0;
    rx_char = '0;
    tx_ev = tx_event_t'(6'h04);
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    rd(OFF_MODEM_CONTROL, 34'h40);
    rd(OFF_SCRATCH_PAD, 34'hff);
    rd(OFF_FEATURE_CONTROL, 34'h00);
    rd(8'h20, {RESP_SLVERR, 32'h0});
    v = $random(seed);
    wr(OFF_SCRATCH_PAD, v[7:0]);
    rd(OFF_SCRATCH_PAD, {26'h0, v[7:0]});
    wr(OFF_MODEM_CONTROL, 8'hbb);
    rd(OFF_MODEM_CONTROL, 34'h5b);
    check(loopback, 1);
    rd(OFF_MODEM_STATUS, 34'hb0, 34'hf0);
    enh_enable <= 1'b1;
    wr(OFF_MODEM_CONTROL, 8'h80);
    rd(OFF_MODEM_CONTROL, 34'h80);
    repeat (4) @(posedge clk);
    n = 0;
    repeat (8) begin
      @(posedge clk);
      n += baud_clk_en;
    end
    check(34'(n), 34'h2);
    wr(OFF_MODEM_CONTROL, 8'h20);
    rd(OFF_MODEM_STATUS, 34'h0, 34'h0);
    msr_int_enable <= 1'b1;
    auto_cts_enable <= 1'b1;
    modem_partner_inst.set_pins(4'he);
    settle();
    rd(OFF_MODEM_STATUS, 34'h11);
    rd(OFF_MODEM_STATUS, 34'h10);
    modem_partner_inst.set_pins(4'ha);
    settle();
    rd(OFF_MODEM_STATUS, 34'h50);
    check(tx_hold, 0);
    modem_partner_inst.set_pins(4'he);
    settle();
    check(msr_irq, 1);
    rd(OFF_MODEM_STATUS, 34'h14);
    settle();
    check(msr_irq, 0);
    modem_partner_inst.set_pins(4'hf);
    settle();
    check(tx_hold, 1);
    lsr_int_enable <= 1'b1;
    repeat (5) push(1'b0);
    settle();
    check(lsr_irq, 1);
    rd(OFF_LINE_STATUS, 34'h03, 34'h9f);
    rd(OFF_LINE_STATUS, 34'h01, 34'h9f);
    settle();
    check(lsr_irq, 0);
    repeat (4) pop();
    settle();
    check(data_ready, 0);
    push(1'b1);
    rd(OFF_LINE_STATUS, 34'h85, 34'h9f);
    pop();
    rd(OFF_LINE_STATUS, 34'h00, 34'h9f);
    tev(6'h20);
    rd(OFF_LINE_STATUS, 34'h00, 34'h60);
    tev(6'h10);
    rd(OFF_LINE_STATUS, 34'h20, 34'h60);
    tev(6'h08);
    rd(OFF_LINE_STATUS, 34'h60, 34'h60);
    wr(OFF_FEATURE_CONTROL, 8'hc5);
    settle();
    check(hyst_active, 1);
    check(hyst_amount, 6'h10);
    wr(OFF_FEATURE_CONTROL, 8'h05);
    settle();
    check(hyst_active, 0);
    wr(OFF_FEATURE_CONTROL, 8'h20);
    wr(OFF_MODEM_STATUS, 8'h30);
    rsx();
    enh_enable <= 1'b0;
    wr(OFF_MODEM_STATUS, 8'h00);
    rsx();
    settle();
    results();
  end
endmodule // tb_uart_line_modem_status

bind uart_line_modem_status uart_lms_checker #(.RX_DEPTH(RX_DEPTH)) uart_lms_checker_inst (.clk,
  .resetn, .axi_req, .axi_rsp, .rx_char, .auto_cts_enable, .lsr_int_enable, .msr_int_enable,
  .tx_serial, .rx_to_receiver, .rts_n, .dtr_n, .loopback, .xon_any_resume, .tx_hold,
  .baud_clk_en, .lsr_irq, .msr_irq, .data_ready);

/* test/uart_lms_checker_assertions.sv */
/*
  checker: port-level assertions for the line and modem status block.
  assumes it is bound onto uart_line_modem_status, one clock, sync reset.
*/
`timescale 1ns/100ps
module uart_lms_checker
  import uart_lms_pkg::*;
#(
  parameter int RX_DEPTH = 64
) (
  input wire logic clk,
  input wire logic resetn,
  input wire axil_req_t axi_req,
  input wire axil_rsp_t axi_rsp,
  input wire rx_char_t rx_char,
  input wire logic auto_cts_enable,
  input wire logic lsr_int_enable,
  input wire logic msr_int_enable,
  input wire logic tx_serial,
  input wire logic rx_to_receiver,
  input wire logic rts_n,
  input wire logic dtr_n,
  input wire logic loopback,
  input wire logic xon_any_resume,
  input wire logic tx_hold,
  input wire logic baud_clk_en,
  input wire logic lsr_irq,
  input wire logic msr_irq,
  input wire logic data_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////
  a_loop_pins_high: assert property (loopback && $past(loopback) |-> rts_n && dtr_n)
    else $error("modem outputs driven in loopback");
  a_loop_rx_feed: assert property (loopback && $past(loopback) |->
    rx_to_receiver == $past(tx_serial))
    else $error("receiver not fed from transmitter in loopback");
  a_baud_gap: assert property (!baud_clk_en |-> ##[1:3] baud_clk_en)
    else $error("baud enable gap too long");
  a_ready_push: assert property (rx_char.valid |=> data_ready)
    else $error("data ready missing after character");
  a_lsr_irq_off: assert property (!lsr_int_enable |-> !lsr_irq)
    else $error("line irq while disabled");
  a_lsr_irq_err: assert property (lsr_int_enable && rx_char.valid && rx_char.par_err ##1
    lsr_int_enable |-> lsr_irq)
    else $error("line irq missing after error character");
  a_msr_irq_off: assert property (!msr_int_enable |-> !msr_irq)
    else $error("modem irq while disabled");
  a_xon_pulse: assert property (xon_any_resume |=> !xon_any_resume)
    else $error("resume pulse too long");
  a_cts_hold_off: assert property (!auto_cts_enable |-> !tx_hold)
    else $error("transmit hold without auto flow");
  a_rdata_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped before taken");
  a_bresp_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped before taken");
  a_ar_refused: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read address taken while answer pending");
  c_slverr: cover property (axi_rsp.rvalid && axi_rsp.rresp == RESP_SLVERR);
  c_lsr_irq: cover property (lsr_irq);
  c_msr_irq: cover property (msr_irq);
  c_loop: cover property (loopback);
endmodule // uart_lms_checker
